// File: hw/crcg_pkg.sv
// constants and carrier types for the coefficient storage checksum guard
package crcg_pkg;

	localparam int CRCG_WORD_W = 24;
	localparam int CRCG_ADDR_W = 8;
	localparam int CRCG_NUM_WORDS = 137;
	localparam int CRCG_BAND_WORDS = 5;
	localparam int CRCG_BAND_A0_SLOT = 4;

	// storage map
	localparam logic [7:0] CRCG_FILTER_FIRST = 8'h00;
	localparam logic [7:0] CRCG_CH1_FILTER_LAST = 8'h3B;
	localparam logic [7:0] CRCG_CH2_FILTER_FIRST = 8'h3C;
	localparam logic [7:0] CRCG_FILTER_LAST = 8'h77;
	localparam logic [7:0] CRCG_CH1_MIX_DIRECT_GAIN = 8'h78;
	localparam logic [7:0] CRCG_CH1_MIX_CROSS_GAIN = 8'h79;
	localparam logic [7:0] CRCG_CH2_MIX_CROSS_GAIN = 8'h7A;
	localparam logic [7:0] CRCG_CH2_MIX_DIRECT_GAIN = 8'h7B;
	localparam logic [7:0] CRCG_CH1_INPUT_SCALE = 8'h7C;
	localparam logic [7:0] CRCG_CH2_INPUT_SCALE = 8'h7D;
	localparam logic [7:0] CRCG_CH1_OUTPUT_SCALE = 8'h7E;
	localparam logic [7:0] CRCG_CH2_OUTPUT_SCALE = 8'h7F;
	localparam logic [7:0] CRCG_OUTPUT_CLIP_LEVEL = 8'h80;
	localparam logic [7:0] CRCG_LIMITER1_ATTACK_LEVEL = 8'h81;
	localparam logic [7:0] CRCG_LIMITER1_RELEASE_LEVEL = 8'h82;
	localparam logic [7:0] CRCG_LIMITER2_ATTACK_LEVEL = 8'h83;
	localparam logic [7:0] CRCG_LIMITER2_RELEASE_LEVEL = 8'h84;
	localparam logic [7:0] CRCG_GATE_CLOSE_LEVEL = 8'h85;
	localparam logic [7:0] CRCG_GATE_OPEN_LEVEL = 8'h86;
	localparam logic [7:0] CRCG_LIMITER1_ENERGY_WEIGHT = 8'h87;
	localparam logic [7:0] CRCG_LIMITER2_ENERGY_WEIGHT = 8'h88;
	localparam logic [7:0] CRCG_LAST_WORD = 8'h88;

	// reset values
	localparam logic [23:0] CRCG_RST_A0 = 24'h200000;
	localparam logic [23:0] CRCG_RST_ZERO = 24'h000000;
	localparam logic [23:0] CRCG_RST_UNITY = 24'h7FFFFF;
	localparam logic [23:0] CRCG_RST_ATTACK = 24'h200000;
	localparam logic [23:0] CRCG_RST_RELEASE = 24'h080000;
	localparam logic [23:0] CRCG_RST_GATE_CLOSE = 24'h00001A;
	localparam logic [23:0] CRCG_RST_GATE_OPEN = 24'h000053;
	localparam logic [23:0] CRCG_RST_ENERGY1 = 24'h008000;
	localparam logic [23:0] CRCG_RST_ENERGY2 = 24'h002000;

	// check sets
	localparam int CRCG_NUM_SETS = 2;
	localparam int CRCG_SET_FILTER = 0;
	localparam int CRCG_SET_LIMITER = 1;

	typedef struct packed {
		logic write;
		logic read;
		logic [CRCG_ADDR_W-1:0] addr;
		logic [CRCG_WORD_W-1:0] wdata;
	} crcg_coef_req_type;

	typedef struct packed {
		logic enable;
		logic auto_mute;
		logic pin_enable;
		logic [CRCG_WORD_W-1:0] reference;
	} crcg_check_ctrl_type;

	typedef struct packed {
		logic [CRCG_WORD_W-1:0] sum_result;
		logic error;
	} crcg_check_stat_type;

	typedef enum logic [0:0] {
		CRCG_SCAN_RUN = 1'b0,
		CRCG_SCAN_WRAP = 1'b1
	} crcg_scan_state_type;

	function automatic logic [23:0] crcg_reset_value(input int idx);
		logic [23:0] v;
		v = CRCG_RST_ZERO;
		if (idx <= int'(CRCG_FILTER_LAST))
		begin
			if ((idx % CRCG_BAND_WORDS) == CRCG_BAND_A0_SLOT)
				v = CRCG_RST_A0;
		end
		else
		begin
			case (idx)
				int'(CRCG_CH1_MIX_DIRECT_GAIN): v = CRCG_RST_UNITY;
				int'(CRCG_CH2_MIX_DIRECT_GAIN): v = CRCG_RST_UNITY;
				int'(CRCG_CH1_INPUT_SCALE): v = CRCG_RST_UNITY;
				int'(CRCG_CH2_INPUT_SCALE): v = CRCG_RST_UNITY;
				int'(CRCG_CH1_OUTPUT_SCALE): v = CRCG_RST_UNITY;
				int'(CRCG_CH2_OUTPUT_SCALE): v = CRCG_RST_UNITY;
				int'(CRCG_OUTPUT_CLIP_LEVEL): v = CRCG_RST_UNITY;
				int'(CRCG_LIMITER1_ATTACK_LEVEL): v = CRCG_RST_ATTACK;
				int'(CRCG_LIMITER2_ATTACK_LEVEL): v = CRCG_RST_ATTACK;
				int'(CRCG_LIMITER1_RELEASE_LEVEL): v = CRCG_RST_RELEASE;
				int'(CRCG_LIMITER2_RELEASE_LEVEL): v = CRCG_RST_RELEASE;
				int'(CRCG_GATE_CLOSE_LEVEL): v = CRCG_RST_GATE_CLOSE;
				int'(CRCG_GATE_OPEN_LEVEL): v = CRCG_RST_GATE_OPEN;
				int'(CRCG_LIMITER1_ENERGY_WEIGHT): v = CRCG_RST_ENERGY1;
				int'(CRCG_LIMITER2_ENERGY_WEIGHT): v = CRCG_RST_ENERGY2;
				default: v = CRCG_RST_ZERO;
			endcase
		end
		return v;
	endfunction : crcg_reset_value

endpackage : crcg_pkg

// File: hw/crcg_sum_scan.sv
// continuous additive checksum scan over the coefficient storage
`timescale 1ns/1ps
module crcg_sum_scan
	import crcg_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// storage read
	input wire logic [CRCG_WORD_W-1:0] i_word,
	output logic [CRCG_ADDR_W-1:0] o_index,
	// results
	output logic [CRCG_WORD_W-1:0] o_filter_sum,
	output logic [CRCG_WORD_W-1:0] o_limiter_sum,
	output logic o_done
);

	crcg_scan_state_type state_r;
	crcg_scan_state_type state_nxt;
	logic [CRCG_ADDR_W-1:0] idx_r;
	logic [CRCG_WORD_W-1:0] facc_r;
	logic [CRCG_WORD_W-1:0] lacc_r;
	logic [CRCG_WORD_W-1:0] fsum_r;
	logic [CRCG_WORD_W-1:0] lsum_r;
	logic done_r;

	wire in_filter = (idx_r <= CRCG_FILTER_LAST);
	wire in_limiter = (idx_r >= CRCG_LIMITER1_ATTACK_LEVEL) && (idx_r <= CRCG_LIMITER2_RELEASE_LEVEL);
	wire last_idx = (idx_r == CRCG_LIMITER2_RELEASE_LEVEL);
	// R17 filter and limiter sums
	// R20 carries drop out of the 24-bit add
	wire [CRCG_WORD_W-1:0] facc_nxt = in_filter ? CRCG_WORD_W'(facc_r + i_word) : facc_r;
	wire [CRCG_WORD_W-1:0] lacc_nxt = in_limiter ? CRCG_WORD_W'(lacc_r + i_word) : lacc_r;

	always_comb
	begin
		case (state_r)
			CRCG_SCAN_RUN: state_nxt = last_idx ? CRCG_SCAN_WRAP : CRCG_SCAN_RUN;
			CRCG_SCAN_WRAP: state_nxt = CRCG_SCAN_RUN;
			default: state_nxt = CRCG_SCAN_RUN;
		endcase
	end

	// one pass takes 134 cycles, far shorter than any audio frame
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			state_r <= CRCG_SCAN_RUN;
			idx_r <= CRCG_FILTER_FIRST;
			facc_r <= CRCG_RST_ZERO;
			lacc_r <= CRCG_RST_ZERO;
			fsum_r <= CRCG_RST_ZERO;
			lsum_r <= CRCG_RST_ZERO;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			done_r <= 1'b0;
			if (state_r == CRCG_SCAN_RUN)
			begin
				if (last_idx)
				begin
					fsum_r <= facc_nxt;
					lsum_r <= lacc_nxt;
					done_r <= 1'b1;
					facc_r <= CRCG_RST_ZERO;
					lacc_r <= CRCG_RST_ZERO;
					idx_r <= CRCG_FILTER_FIRST;
				end
				else
				begin
					facc_r <= facc_nxt;
					lacc_r <= lacc_nxt;
					idx_r <= idx_r + 8'h01;
				end
			end
		end
	end

	assign o_index = idx_r;
	assign o_filter_sum = fsum_r;
	assign o_limiter_sum = lsum_r;
	assign o_done = done_r;

endmodule : crcg_sum_scan

// File: hw/crcg_top.sv
// coefficient storage with per-frame checksum guard, protection pin and auto-mute
//
// Summary of operation
// R1 - host loads filter words 0x00-0x77 first
// R2 - host writes reference, then sets enable
// R3 - enable starts checksum, result readable
// R4 - every frame compare, error is mismatch
// R5 - failure with pin enable pulls pin low
// R6 - auto-mute mutes while error each frame
// R7 - matching coefficients clear error, release mute
// R8 - limiter thresholds get identical separate check
// R9 - twelve five-word bands per channel
// R10 - band reset is pass-through filter
// R11 - mixer resets to direct unity, cross zero
// R12 - input and output scales reset unity
// R13 - shared clip level at 0x80, unity
// R14 - limiter thresholds at 0x81-0x84 with resets
// R15 - gate levels reset 0x1A and 0x53
// R16 - limiter energy weights at 0x87, 0x88
// R17 - sums over 0x00-0x77 and 0x81-0x84
// R18 - both 24-bit sums readable
// R19 - auto-mute needs its check enabled
// R20 - wrap modulo 2^24, scan within frame
`timescale 1ns/1ps
module crcg_top
	import crcg_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// coefficient storage access
	input wire crcg_coef_req_type i_coef_req,
	output logic [CRCG_WORD_W-1:0] o_coef_rdata,
	output logic o_coef_rvalid,
	// audio frame clock pin
	input wire logic i_frame_clk,
	// check controls
	input wire crcg_check_ctrl_type i_filter_check,
	input wire crcg_check_ctrl_type i_limiter_check,
	// check status
	output crcg_check_stat_type o_filter_status,
	output crcg_check_stat_type o_limiter_status,
	// protection pin, open drain
	output logic o_protection_out_n_o,
	output logic o_protection_out_n_oe,
	// mute request to the output stage
	output logic o_mute
);

	// storage
	logic [CRCG_WORD_W-1:0] coef_r [CRCG_NUM_WORDS];
	logic [CRCG_WORD_W-1:0] rdata_r;
	logic rvalid_r;

	// frame pin synchroniser and edge
	logic frame_meta_r;
	logic frame_sync_r;
	logic frame_prev_r;

	// scanner
	logic [CRCG_ADDR_W-1:0] scan_idx;
	logic [CRCG_WORD_W-1:0] scan_word;
	logic [CRCG_WORD_W-1:0] scan_fsum;
	logic [CRCG_WORD_W-1:0] scan_lsum;
	logic scan_done;

	// per-set check state
	crcg_check_ctrl_type ctrl [CRCG_NUM_SETS];
	logic [CRCG_WORD_W-1:0] scan_sum [CRCG_NUM_SETS];
	logic [CRCG_WORD_W-1:0] result_r [CRCG_NUM_SETS];
	logic fresh_r [CRCG_NUM_SETS];
	logic error_r [CRCG_NUM_SETS];
	logic pin_req [CRCG_NUM_SETS];
	logic mute_req [CRCG_NUM_SETS];

	wire addr_ok = (i_coef_req.addr <= CRCG_LAST_WORD);
	wire wr_hit = i_coef_req.write && addr_ok;
	wire frame_tick = frame_sync_r && !frame_prev_r;

	assign ctrl[CRCG_SET_FILTER] = i_filter_check;
	assign ctrl[CRCG_SET_LIMITER] = i_limiter_check;
	assign scan_sum[CRCG_SET_FILTER] = scan_fsum;
	assign scan_sum[CRCG_SET_LIMITER] = scan_lsum;

	// R9 flat word map, bands of five words
	// R10 R11 R12 R13 R14 R15 R16 per-word reset values
	genvar gw;
	generate
		for (gw = 0; gw < CRCG_NUM_WORDS; gw++)
		begin : g_word
			localparam logic [CRCG_ADDR_W-1:0] WORD_ADDR = CRCG_ADDR_W'(gw);
			localparam logic [CRCG_WORD_W-1:0] WORD_RST = crcg_reset_value(gw);
			always_ff @(posedge i_clk_sys)
			begin
				if (!i_resetn)
					coef_r[gw] <= WORD_RST;
				else if (wr_hit && (i_coef_req.addr == WORD_ADDR))
					coef_r[gw] <= i_coef_req.wdata;
			end
		end
	endgenerate

	// unmapped words read as zero
	wire [CRCG_WORD_W-1:0] rd_word = addr_ok ? coef_r[i_coef_req.addr] : CRCG_RST_ZERO;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			rdata_r <= CRCG_RST_ZERO;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= i_coef_req.read;
			if (i_coef_req.read)
				rdata_r <= rd_word;
		end
	end

	// frame pin is asynchronous to the system clock
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			frame_meta_r <= 1'b0;
			frame_sync_r <= 1'b0;
			frame_prev_r <= 1'b0;
		end
		else
		begin
			frame_meta_r <= i_frame_clk;
			frame_sync_r <= frame_meta_r;
			frame_prev_r <= frame_sync_r;
		end
	end

	// scanner reads storage as it stands; a write mid-pass shows in this pass if its word is not yet scanned, else in the next pass
	assign scan_word = (scan_idx <= CRCG_LAST_WORD) ? coef_r[scan_idx] : CRCG_RST_ZERO;

	// R17 addition over both ranges
	// R20 pass finishes well inside a frame
	crcg_sum_scan u_scan (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_word(scan_word),
		.o_index(scan_idx),
		.o_filter_sum(scan_fsum),
		.o_limiter_sum(scan_lsum),
		.o_done(scan_done)
	);

	// R8 one identical check per set
	genvar gs;
	generate
		for (gs = 0; gs < CRCG_NUM_SETS; gs++)
		begin : g_set
			// R3 result tracks only while enabled
			always_ff @(posedge i_clk_sys)
			begin
				if (!i_resetn)
				begin
					result_r[gs] <= CRCG_RST_ZERO;
					fresh_r[gs] <= 1'b0;
				end
				else if (!ctrl[gs].enable)
					fresh_r[gs] <= 1'b0;
				else if (scan_done)
				begin
					result_r[gs] <= scan_sum[gs];
					fresh_r[gs] <= 1'b1;
				end
			end

			// R4 compare once per audio frame
			// R7 a matching pass clears the error
			// stale sums from before enabling are never compared
			always_ff @(posedge i_clk_sys)
			begin
				if (!i_resetn)
					error_r[gs] <= 1'b0;
				else if (!ctrl[gs].enable)
					error_r[gs] <= 1'b0;
				else if (frame_tick && fresh_r[gs])
					error_r[gs] <= (result_r[gs] != ctrl[gs].reference);
			end

			// R5 pin request on failure
			assign pin_req[gs] = error_r[gs] && ctrl[gs].pin_enable;
			// R6 mute while failure stands
			// R19 mute only with check enabled
			assign mute_req[gs] = error_r[gs] && ctrl[gs].auto_mute && ctrl[gs].enable;
		end
	endgenerate

	// R18 sums exposed for reading
	assign o_filter_status.sum_result = result_r[CRCG_SET_FILTER];
	assign o_filter_status.error = error_r[CRCG_SET_FILTER];
	assign o_limiter_status.sum_result = result_r[CRCG_SET_LIMITER];
	assign o_limiter_status.error = error_r[CRCG_SET_LIMITER];

	// R5 open drain: only ever drives low
	assign o_protection_out_n_o = 1'b0;
	assign o_protection_out_n_oe = pin_req[CRCG_SET_FILTER] || pin_req[CRCG_SET_LIMITER];
	// R7 mute drops as soon as the error clears
	assign o_mute = mute_req[CRCG_SET_FILTER] || mute_req[CRCG_SET_LIMITER];

	assign o_coef_rdata = rdata_r;
	assign o_coef_rvalid = rvalid_r;

endmodule : crcg_top

// File: sim/crcg_host_model.sv
// behavioural control-bus host that loads and reads coefficient words
`timescale 1ns/1ps
module crcg_host_model
	import crcg_pkg::*;
(
	// clock
	input wire logic i_clk_sys,
	// storage answer
	input wire logic [CRCG_WORD_W-1:0] i_rdata,
	input wire logic i_rvalid,
	// storage request
	output crcg_coef_req_type o_req
);
	initial o_req = '0;

	// released lines show the inverse, so a stale value is never mistaken for a held one
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge i_clk_sys);
		o_req <= '{1'b1, 1'b0, a, d};
		@(negedge i_clk_sys);
		o_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic v);
		@(negedge i_clk_sys);
		o_req <= '{1'b0, 1'b1, a, 24'h000000};
		@(negedge i_clk_sys);
		o_req <= '{1'b0, 1'b0, ~a, 24'hA5A5A5};
		d = i_rdata;
		v = i_rvalid;
	endtask : rd
endmodule : crcg_host_model

// File: sim/crcg_monitor.sv
// port assertions for the coefficient checksum guard
`timescale 1ns/1ps
module crcg_monitor
	import crcg_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// storage port
	input wire crcg_coef_req_type i_coef_req,
	input wire logic [CRCG_WORD_W-1:0] o_coef_rdata,
	input wire logic o_coef_rvalid,
	// checks
	input wire logic i_frame_clk,
	input wire crcg_check_ctrl_type i_filter_check,
	input wire crcg_check_ctrl_type i_limiter_check,
	input wire crcg_check_stat_type o_filter_status,
	input wire crcg_check_stat_type o_limiter_status,
	// pin and mute
	input wire logic o_protection_out_n_o,
	input wire logic o_protection_out_n_oe,
	input wire logic o_mute
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	wire fe = o_filter_status.error;
	wire le = o_limiter_status.error;

	a_pin_low_only: assert property (o_protection_out_n_oe |-> o_protection_out_n_o == 1'b0)
		else $error("protection pin driven high");
	a_pin_follows_error: assert property (o_protection_out_n_oe ==
		((fe & i_filter_check.pin_enable) | (le & i_limiter_check.pin_enable)))
		else $error("protection pin does not follow errors");
	a_mute_follows_error: assert property (o_mute ==
		((fe & i_filter_check.auto_mute & i_filter_check.enable) |
		(le & i_limiter_check.auto_mute & i_limiter_check.enable)))
		else $error("mute does not follow errors");
	a_read_answered: assert property (i_coef_req.read |=> o_coef_rvalid)
		else $error("read not answered");
	a_answer_has_cause: assert property (o_coef_rvalid |-> $past(i_coef_req.read))
		else $error("read answer without request");
	a_rdata_holds: assert property (!o_coef_rvalid |-> $stable(o_coef_rdata))
		else $error("read data moved without answer");
	a_filter_off_clear: assert property (!i_filter_check.enable |=> !fe)
		else $error("filter error set while disabled");
	a_limiter_off_clear: assert property (!i_limiter_check.enable |=> !le)
		else $error("limiter error set while disabled");
	a_error_needs_enable: assert property ($rose(fe) |-> $past(i_filter_check.enable))
		else $error("filter error rose without enable");
endmodule : crcg_monitor

bind crcg_top crcg_monitor u_mon (.i_clk_sys, .i_resetn, .i_coef_req, .o_coef_rdata, .o_coef_rvalid,
	.i_frame_clk, .i_filter_check, .i_limiter_check, .o_filter_status, .o_limiter_status,
	.o_protection_out_n_o, .o_protection_out_n_oe, .o_mute);

// File: sim/tb.sv
// self-checking bench for the coefficient checksum guard
`timescale 1ns/1ps
module tb;
	import crcg_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic frame = 1'b0;
	crcg_check_ctrl_type fc = '0;
	crcg_check_ctrl_type lc = '0;
	crcg_coef_req_type req;
	crcg_check_stat_type fs, ls;
	logic [23:0] rdata;
	logic [23:0] mem [0:136];
	logic rvalid, pin_d, pin_oe, mute;
	wire pin_n;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;

	initial forever #10 clk = ~clk;
	crcg_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
	crcg_top dut (.i_clk_sys(clk), .i_resetn(rstn), .i_coef_req(req), .o_coef_rdata(rdata),
		.o_coef_rvalid(rvalid), .i_frame_clk(frame), .i_filter_check(fc), .i_limiter_check(lc),
		.o_filter_status(fs), .o_limiter_status(ls), .o_protection_out_n_o(pin_d),
		.o_protection_out_n_oe(pin_oe), .o_mute(mute));
	// open-drain pin with pull-up
	assign pin_n = pin_oe ? pin_d : 1'b1;

	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [23:0] rst_val(int a);
		if (a <= 8'h77)
			return (a % 5 == 4) ? 24'h200000 : 24'h000000;
		case (a)
			8'h78, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h7F, 8'h80: return 24'h7FFFFF;
			8'h81, 8'h83: return 24'h200000;
			8'h82, 8'h84: return 24'h080000;
			8'h85: return 24'h00001A;
			8'h86: return 24'h000053;
			8'h87: return 24'h008000;
			8'h88: return 24'h002000;
			default: return 24'h000000;
		endcase
	endfunction : rst_val

	function automatic logic [23:0] sum(int lo, int hi);
		logic [23:0] s = 24'h000000;
		for (int i = lo; i <= hi; i++)
			s += mem[i];
		return s;
	endfunction : sum

	// two scan passes fit in the wait, then one frame pulse
	task automatic frame_check();
		logic fe, le;
		repeat (280) @(negedge clk);
		fe = fc.enable && sum(0, 8'h77) != fc.reference;
		le = lc.enable && sum(8'h81, 8'h84) != lc.reference;
		chk("filter sum", sum(0, 8'h77), fs.sum_result);
		chk("limiter sum", sum(8'h81, 8'h84), ls.sum_result);
		frame = 1'b1;
		repeat (8) @(negedge clk);
		frame = 1'b0;
		chk("filter error", fe, fs.error);
		chk("limiter error", le, ls.error);
		chk("mute", (fe & fc.auto_mute) | (le & lc.auto_mute), mute);
		chk("pin", !((fe & fc.pin_enable) | (le & lc.pin_enable)), pin_n);
	endtask : frame_check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fails++;
			print_verdict();
		end
	end

	initial
	begin
		logic [23:0] d, old;
		logic v;
		int a;
		void'($urandom(90));
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i <= 8'h88; i++)
		begin
			mem[i] = rst_val(i);
			host.rd(8'(i), d, v);
			chk("read valid", 1'b1, v);
			chk("reset word", mem[i], d);
		end
		host.wr(8'h90, 24'($urandom));
		host.rd(8'h90, d, v);
		chk("unmapped word", 24'h000000, d);
		$display("reset map done");
		fc.reference = sum(0, 8'h77);
		lc.reference = sum(8'h81, 8'h84);
		@(negedge clk);
		fc.enable = 1'b1;
		lc.enable = 1'b1;
		frame_check();
		for (int r = 0; r < 7; r++)
		begin
			{fc.auto_mute, fc.pin_enable, lc.auto_mute, lc.pin_enable} = (r < 2) ? 4'hF : 4'($urandom);
			a = (r % 2) ? $urandom_range(8'h84, 8'h81) : $urandom_range(8'h77, 0);
			old = mem[a];
			mem[a] = 24'($urandom);
			host.wr(8'(a), mem[a]);
			// the last round drops both enables with the fault still present
			// disabled sets keep their last sums, which still match the storage here
			if (r == 6)
			begin
				frame_check();
				fc.enable = 1'b0;
				lc.enable = 1'b0;
			end
			frame_check();
			mem[a] = old;
			host.wr(8'(a), old);
			// references unchanged, so re-arming needs only the enables
			fc.enable = 1'b1;
			lc.enable = 1'b1;
			frame_check();
			$display("round %0d done", r);
		end
		print_verdict();
	end
endmodule : tb
